// ---- hdl/astg_defs.vh ----
/*
 * Constants for the alarm status and transmit gating register block:
 * register indices, field positions, reset values and bit masks.
 * Assumes inclusion by astg_alarm_regs.v only.
 */
`ifndef ASTG_DEFS_VH
`define ASTG_DEFS_VH

// register indices, byte address is four times the index
`define ASTG_IDX_SCALE 4'h3
`define ASTG_IDX_PFAIL 4'h4
`define ASTG_IDX_ALARM 4'h5
`define ASTG_IDX_MASK 4'h7

// reset values
`define ASTG_SCALE_RST 16'hF000
`define ASTG_MASK_RST 16'hFFFF
`define ASTG_CLR_RST 16'h0000

// scale and transmit enable fields
`define ASTG_SCALE_HI 15
`define ASTG_SCALE_LO 12
`define ASTG_TXEN_BIT 0
`define ASTG_SCALE_WMASK 16'hF001

// alarm bit positions
`define ASTG_AL_ZERO 15
`define ASTG_AL_COLL 13
`define ASTG_AL_ONE 12
`define ASTG_AL_TWO 11
`define ASTG_AL_DACCLK 10
`define ASTG_AL_DATACLK 9
`define ASTG_AL_MUTE 8
`define ASTG_AL_PAT 7
`define ASTG_ALARM_WMASK 16'hBF80

// output code forced while muted
`define ASTG_MID_SCALE 16'h8000

`endif

// ---- hdl/astg_alarm_regs.v ----
/*
 * Alarm status, pattern failure and transmit gating registers with an
 * APB slave, sticky write-one-to-clear alarms, interrupt and output mute.
 * Assumes FIFO, pattern and sample inputs on pclk; clock-loss flags and
 * the transmit enable pin asynchronous.
 */
// The APB slave port was left to the implementer.
//
// Behaviour
// - 4-bit full-scale step, bits 15:12, resets 1111
// - transmit enable is software bit OR pin
// - failure bit set per failing bus bit
// - bit 15 set when write pointer zero
// - pointer field 13:11: collision, one, two
// - bit 10 set on conversion clock loss
// - bit 9 set on data clock loss
// - bit 8 set on clock loss or collision
// - mid-scale 0x8000 on outputs while muted
// - bit 7 set on pattern mismatch
// - failure register cleared by write, not read
// - alarm register cleared by software write
// - alarm mask resets 0xFFFF, one masks
`timescale 1ns/1ps
`include "astg_defs.vh"

module astg_alarm_regs #(
  parameter AW = 12,
  parameter NCH = 4
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire tx_enable_pin,
  input wire dacclk_lost,
  input wire dataclk_lost,
  input wire [7:0] wr_ptr,
  input wire fifo_two_away,
  input wire fifo_one_away,
  input wire fifo_collision,
  input wire pat_valid,
  input wire [15:0] ab_data_bus,
  input wire [15:0] cd_data_bus,
  input wire [15:0] ab_pattern,
  input wire [15:0] cd_pattern,
  input wire [16*NCH-1:0] sample_in,
  output reg [16*NCH-1:0] dac_out,
  output reg [3:0] coarse_scale,
  output reg tx_enable,
  output reg irq
);

////////////////////////////////////////////////////////////////////////
// input synchronisers

reg [2:0] sync1_q;
reg [2:0] sync2_q;
wire [2:0] async_in;

// each asynchronous input gets its own two-flop chain
assign async_in = {tx_enable_pin, dataclk_lost, dacclk_lost};

genvar sb;
generate
  for (sb = 0; sb < 3; sb = sb + 1) begin : g_sync
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1_q[sb] <= 1'b0;
        sync2_q[sb] <= 1'b0;
      end else begin
        sync1_q[sb] <= async_in[sb];
        sync2_q[sb] <= sync1_q[sb];
      end
    end
  end
endgenerate

wire dacclk_lost_s;
wire dataclk_lost_s;
wire tx_pin_s;

assign dacclk_lost_s = sync2_q[0];
assign dataclk_lost_s = sync2_q[1];
assign tx_pin_s = sync2_q[2];

////////////////////////////////////////////////////////////////////////
// apb decode

wire [3:0] idx;
wire acc;
wire wr_en;
wire sel_scale;
wire sel_pfail;
wire sel_alarm;
wire sel_mask;
wire mapped;
wire wr_scale;
wire wr_pfail;
wire wr_alarm;
wire wr_mask;

assign idx = paddr[5:2];
assign acc = psel & penable;
// unmapped writes must not alias onto a register
assign wr_en = acc & pready & pwrite & mapped;
assign sel_scale = (idx == `ASTG_IDX_SCALE);
assign sel_pfail = (idx == `ASTG_IDX_PFAIL);
assign sel_alarm = (idx == `ASTG_IDX_ALARM);
assign sel_mask = (idx == `ASTG_IDX_MASK);
assign mapped = (paddr[AW-1:6] == {(AW-6){1'b0}}) &
                (paddr[1:0] == 2'h0) &
                (sel_scale | sel_pfail | sel_alarm | sel_mask);

assign wr_scale = wr_en & sel_scale;
assign wr_pfail = wr_en & sel_pfail;
assign wr_alarm = wr_en & sel_alarm;
assign wr_mask = wr_en & sel_mask;

////////////////////////////////////////////////////////////////////////
// registers

reg [15:0] scale_q;
reg [15:0] pfail_q;
reg [15:0] alarm_q;
reg [15:0] mask_q;

wire [15:0] pfail_set;
wire [15:0] alarm_set;
wire [15:0] pfail_clr;
wire [15:0] alarm_clr;
wire ptr_zero;
wire mute_cond;

// per-bit compare against the expected words
assign pfail_set = pat_valid ?
  ((ab_data_bus ^ ab_pattern) | (cd_data_bus ^ cd_pattern)) :
  16'h0000;

assign ptr_zero = (wr_ptr == 8'h00);
assign mute_cond = dacclk_lost_s | dataclk_lost_s | fifo_collision;

// clock-loss flags arrive two cycles late through the synchronisers
// pointer bits latch apart, so the 01x and 1xx codes follow
assign alarm_set[`ASTG_AL_ZERO] = ptr_zero;
assign alarm_set[14] = 1'b0;
assign alarm_set[`ASTG_AL_COLL] = fifo_collision;
assign alarm_set[`ASTG_AL_ONE] = fifo_one_away;
assign alarm_set[`ASTG_AL_TWO] = fifo_two_away;
assign alarm_set[`ASTG_AL_DACCLK] = dacclk_lost_s;
assign alarm_set[`ASTG_AL_DATACLK] = dataclk_lost_s;
assign alarm_set[`ASTG_AL_MUTE] = mute_cond;
assign alarm_set[`ASTG_AL_PAT] = |pfail_set;
assign alarm_set[6:0] = 7'h00;

assign pfail_clr = wr_pfail ? pwdata[15:0] :
                   16'h0000;
assign alarm_clr = wr_alarm ?
                   (pwdata[15:0] & `ASTG_ALARM_WMASK) :
                   16'h0000;

// scale and transmit enable, reserved bits read zero
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    scale_q <= `ASTG_SCALE_RST;
  end else if (wr_scale) begin
    scale_q <= pwdata[15:0] & `ASTG_SCALE_WMASK;
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    mask_q <= `ASTG_MASK_RST;
  end else if (wr_mask) begin
    mask_q <= pwdata[15:0];
  end
end

// sticky per bit; set wins over a clear landing in the same cycle
genvar bt;
generate
  for (bt = 0; bt < 16; bt = bt + 1) begin : g_sticky
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pfail_q[bt] <= 1'b0;
        alarm_q[bt] <= 1'b0;
      end else begin
        pfail_q[bt] <= (pfail_q[bt] & ~pfail_clr[bt]) |
                       pfail_set[bt];
        alarm_q[bt] <= (alarm_q[bt] & ~alarm_clr[bt]) |
                       alarm_set[bt];
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////
// apb answer, one wait state

localparam ST_IDLE = 1'b0;
localparam ST_ANSWER = 1'b1;

reg st_q;
reg st_d;

// first access cycle is the wait state, answer in the next one
always @* begin
  st_d = ST_IDLE;
  case (st_q)
    ST_IDLE: begin
      if (acc) begin
        st_d = ST_ANSWER;
      end
    end
    ST_ANSWER: begin
      st_d = ST_IDLE;
    end
    default: begin
      st_d = ST_IDLE;
    end
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    st_q <= ST_IDLE;
  end else begin
    st_q <= st_d;
  end
end

reg [15:0] rd_mux;

always @* begin
  rd_mux = 16'h0000;
  case (idx)
    `ASTG_IDX_SCALE: rd_mux = scale_q;
    `ASTG_IDX_PFAIL: rd_mux = pfail_q;
    `ASTG_IDX_ALARM: rd_mux = alarm_q;
    `ASTG_IDX_MASK: rd_mux = mask_q;
    default: rd_mux = 16'h0000;
  endcase
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h00000000;
  end else if (st_d == ST_ANSWER) begin
    pready <= 1'b1;
    pslverr <= ~mapped;
    prdata <= (mapped & ~pwrite) ? {16'h0000, rd_mux} :
              32'h00000000;
  end else begin
    pready <= 1'b0;
    pslverr <= 1'b0;
    prdata <= 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////
// control outputs and interrupt
// irq covers the alarm register only; the mute ignores the mask

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    coarse_scale <= 4'h0;
    tx_enable <= 1'b0;
    irq <= 1'b0;
  end else begin
    coarse_scale <= scale_q[`ASTG_SCALE_HI:`ASTG_SCALE_LO];
    tx_enable <= scale_q[`ASTG_TXEN_BIT] | tx_pin_s;
    irq <= |(alarm_q & ~mask_q);
  end
end

////////////////////////////////////////////////////////////////////////
// output path, mid-scale while muted

genvar ch;
generate
  for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dac_out[16*ch +: 16] <= `ASTG_MID_SCALE;
      end else if (alarm_q[`ASTG_AL_MUTE]) begin
        dac_out[16*ch +: 16] <= `ASTG_MID_SCALE;
      end else begin
        dac_out[16*ch +: 16] <= sample_in[16*ch +: 16];
      end
    end
  end
endgenerate

endmodule

// ---- test/astg_checker.sv ----
/* checker for astg_alarm_regs: apb timing, mute, scale, tx gating.
   assumes binding onto the design's own ports. */
`timescale 1ns/1ps
module astg_checker #(
  parameter NCH = 4
) (
  input logic pclk,
  input logic presetn,
  input logic penable,
  input logic pwrite,
  input logic pready,
  input logic pslverr,
  input logic [31:0] prdata,
  input logic tx_enable_pin,
  input logic tx_enable,
  input logic fifo_collision,
  input logic [16*NCH-1:0] dac_out,
  input logic [3:0] coarse_scale,
  input logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
////////////////////////////////////////
  a_one_wait: assert property ($rose(penable) |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read half not zero");
  a_mute_mid: assert property (
    fifo_collision |-> ##3 dac_out == {NCH{16'h8000}})
    else $error("outputs not mid-scale after collision");
  a_tx_pin: assert property (tx_enable_pin [*4] |=> tx_enable)
    else $error("pin did not enable transmit");
  a_scale_reset: assert property ($rose(presetn) |=> coarse_scale == 4'hF)
    else $error("scale not full after reset");
////////////////////////////////////////
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
  c_mute: cover property (dac_out == {NCH{16'h8000}} && pready);
endmodule
bind astg_alarm_regs astg_checker #(.NCH(NCH)) u_chk (.*);

// ---- test/alarm_status_and_tx_gating_test.sv ----
/* bench: apb tasks and scenarios for the alarm register block.
   assumes design and bound checker compiled alongside. */
`timescale 1ns/1ps
module alarm_status_and_tx_gating_test;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg tx_enable_pin = 0, dacclk_lost = 0, dataclk_lost = 0;
  reg fifo_two_away = 0, fifo_one_away = 0, fifo_collision = 0;
  reg pat_valid = 0, err;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg [7:0] wr_ptr = 8'h01;
  reg [15:0] ab_data_bus = 0, cd_data_bus = 0;
  reg [15:0] ab_pattern = 0, cd_pattern = 0;
  reg [63:0] sample_in = 64'h0123456789ABCDEF;
  wire [31:0] prdata;
  wire [63:0] dac_out;
  wire [3:0] coarse_scale;
  wire pready, pslverr, tx_enable, irq;
  integer bad_count = 0, num_checks = 0, i, k;
  astg_alarm_regs DUT (.*);
  always #12.5 pclk = ~pclk;
////////////////////////////////////////
  task conclude;
    begin
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input string n, input [63:0] e, input [63:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("Error %s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
        bad_count = bad_count + 1;
        conclude;
      end
    end
  endtask
  task rchk(input string n, input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(n, e, rd);
    end
  endtask
////////////////////////////////////////
  task t_scale;
    begin
      rchk("scale", 12'h00C, 32'hF000);
      rchk("mask", 12'h01C, 32'hFFFF);
      chk("tx", 1'b0, tx_enable);
      apb(1'b1, 12'h00C, 32'hFFFFA5A1);
      rchk("scale", 12'h00C, 32'hA001);
      chk("coarse", 4'hA, coarse_scale);
      chk("tx", 1'b1, tx_enable);
      apb(1'b1, 12'h00C, 32'h0);
      cyc(2);
      chk("tx", 1'b0, tx_enable);
      tx_enable_pin <= 1;
      cyc(5);
      chk("tx", 1'b1, tx_enable);
      tx_enable_pin <= 0;
      cyc(5);
      chk("tx", 1'b0, tx_enable);
    end
  endtask
  task t_fifo;
    for (i = 0; i < 3; i = i + 1) begin
      {fifo_collision, fifo_one_away, fifo_two_away} <= 3'h1 << i;
      cyc(2);
      {fifo_collision, fifo_one_away, fifo_two_away} <= 3'h0;
      rchk("fifo", 12'h014, (32'h800 << i) | (i == 2 ? 32'h100 : 0));
      apb(1'b1, 12'h014, 32'hFFFF);
      cyc(2);
      chk("dac", sample_in, dac_out);
    end
  endtask
  task t_clock;
    begin
      apb(1'b1, 12'h01C, 32'h0);
      wr_ptr <= 8'h00;
      dacclk_lost <= 1;
      dataclk_lost <= 1;
      cyc(4);
      wr_ptr <= 8'h02;
      dacclk_lost <= 0;
      dataclk_lost <= 0;
      cyc(4);
      rchk("alarm", 12'h014, 32'h8700);
      chk("mute", {4{16'h8000}}, dac_out);
      chk("irq", 1'b1, irq);
      apb(1'b1, 12'h01C, 32'hFFFF);
      cyc(2);
      chk("irq", 1'b0, irq);
      apb(1'b1, 12'h014, 32'h0400);
      rchk("alarm", 12'h014, 32'h8300);
      apb(1'b1, 12'h014, 32'hFFFF);
      cyc(2);
      chk("dac", sample_in, dac_out);
    end
  endtask
  task t_pattern;
    begin
      ab_pattern <= 16'h1234;
      cd_pattern <= 16'hABCD;
      ab_data_bus <= 16'h1334;
      cd_data_bus <= 16'hABCF;
      pat_valid <= 1;
      cyc(1);
      pat_valid <= 0;
      rchk("pfail", 12'h010, 32'h0102);
      rchk("alarm", 12'h014, 32'h0080);
      chk("pat alarm", 1'b1, rd[7]);
      rchk("pfail", 12'h010, 32'h0102);
      apb(1'b1, 12'h010, 32'h0100);
      rchk("pfail", 12'h010, 32'h0002);
      rchk("none", 12'h018, 32'h0);
      chk("slverr", 1'b1, err);
    end
  endtask
  task t_refuse;
    begin
      apb(1'b1, 12'h40C, 32'h0000F001);
      chk("slverr", 1'b1, err);
      apb(1'b1, 12'h00D, 32'h0000F001);
      chk("slverr", 1'b1, err);
      rchk("scale", 12'h00C, 32'h0);
      chk("slverr", 1'b0, err);
    end
  endtask
  task t_sticky;
    begin
      apb(1'b1, 12'h014, 32'hFFFF);
      fifo_two_away <= 1;
      apb(1'b1, 12'h014, 32'h0800);
      rchk("set wins", 12'h014, 32'h0800);
      fifo_two_away <= 0;
      apb(1'b1, 12'h014, 32'h0800);
      rchk("cleared", 12'h014, 32'h0);
    end
  endtask
  task t_reset;
    begin
      apb(1'b1, 12'h00C, 32'h0000A001);
      presetn <= 0;
      cyc(2);
      presetn <= 1;
      rchk("scale", 12'h00C, 32'hF000);
      rchk("mask", 12'h01C, 32'hFFFF);
      chk("coarse", 4'hF, coarse_scale);
      chk("tx", 1'b0, tx_enable);
    end
  endtask
////////////////////////////////////////
  initial begin
    cyc(10);
    presetn <= 1;
    t_scale;
    t_fifo;
    t_clock;
    t_pattern;
    t_refuse;
    t_sticky;
    t_reset;
    conclude;
  end
endmodule
